// *** gpmx_board.sv ***
// Board model: input pin levels and core supply sense.
// Levels follow the bench's request LAG+1 cycles late; slow boards use a larger LAG.
`timescale 1ns/1ps
module gpmx_board #(parameter int LAG = 1) (
  // Clock
  input wire logic ref_clk,
  // Requested levels
  input wire logic [21:0] want_pins,
  input wire logic want_power_lost,
  // Board lines
  output logic [21:0] gpi_pin,
  output logic core_power_lost
);
  logic [22:0] pipe_q [0:7];
  initial begin
    for (int i = 0; i < 8; i++) pipe_q[i] = 23'h000000;
  end
  always @(posedge ref_clk) begin
    pipe_q[0] <= {want_power_lost, want_pins};
    for (int i = 1; i < 8; i++) pipe_q[i] <= pipe_q[i-1];
  end
  assign {core_power_lost, gpi_pin} = pipe_q[LAG];
endmodule

// *** gpmx_pin_mux.sv ***
// Top of the general-purpose pin mux: output and input level registers
// in power-management I/O space, per-pin alternate routing.
// Assumes the I/O decoder presents one access per cycle on ref_clk and
// that configuration words come from registers on the same clock.
`timescale 1ns/1ps
`include "gpmx_regs.svh"
module gpmx_pin_mux (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // I/O space access
  input wire logic [15:0] power_mgmt_io_base,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  output logic [31:0] io_rdata,
  output logic io_rd_valid,
  // Configuration words
  input wire logic [31:0] general_configuration,
  input wire logic [15:0] xbus_chip_select_config,
  // Package pins
  input wire logic [21:0] gpi_pin,
  input wire logic core_power_lost,
  output logic [30:0] gpo_pin,
  // Alternate logic driving output pins
  input wire logic [6:0] latched_upper_address,
  input wire logic [2:0] pcpci_grant_n,
  input wire logic ext_intc_ack_n,
  input wire logic ext_intc_select_n,
  input wire logic ext_intc_timer_irq,
  input wire logic secondary_plane_ctl_n,
  input wire logic tertiary_plane_ctl_n,
  input wire logic processor_clock_stop_n,
  input wire logic bus_clock_stop_n,
  input wire logic cache_power_down,
  input wire logic suspend_status_one_n,
  input wire logic suspend_status_two_n,
  input wire logic xbus_direction_n,
  input wire logic xbus_output_enable_n,
  input wire logic ext_clock_select_n,
  input wire logic ext_clock_addr_strobe,
  input wire logic keyboard_ctl_select_n,
  input wire logic interrupt_nine_out_n,
  // Pin levels handed to alternate logic, idle high when not selected
  output logic channel_check_n,
  output logic [2:0] pcpci_request_n,
  output logic ext_intc_request_n,
  output logic clock_interrupt_n,
  output logic serial_interrupt_line,
  output logic thermal_alarm_n,
  output logic battery_low_n,
  output logic lid_switch_n,
  output logic mgmt_bus_alert_n,
  output logic ring_indicate_n,
  // Power management view of input 1
  output logic pm_input_one_active
);

  localparam gpmx_pkg::gpmx_state_t RESET_STATE = '{
    out_levels: `GPMX_OUT_LEVELS_RESET,
    out_pins: (31'(`GPMX_OUT_LEVELS_RESET) & ~`GPMX_ALT_DEFAULT_MASK)
      | (`GPMX_ALT_RESET & `GPMX_ALT_DEFAULT_MASK),
    in_levels: 22'h00_0000,
    alt_in: `GPMX_ALT_IN_IDLE,
    pm_in1_active: 1'b0,
    rdata: 32'h0000_0000,
    rd_valid: 1'b0
  };

  gpmx_pkg::gpmx_state_t s_q;
  gpmx_pkg::gpmx_state_t s_d;

  logic [22:0] pins_sync;
  logic [21:0] in_sync;
  logic power_lost_sync;
  logic [21:0] in_alt_sel;
  logic [30:0] out_alt_sel;
  logic [30:0] alt_drive;
  logic [30:0] pin_next;
  logic [31:0] merged;
  logic wr_out_hit;
  logic rd_out_hit;
  logic rd_in_hit;

  // Same offset check for reads and writes
  function automatic logic addr_hit(
    input logic [15:0] addr,
    input logic [15:0] base,
    input logic [15:0] off
  );
    logic [15:0] target;
    target = base + off;
    addr_hit = (addr == target);
  endfunction

  // Byte-lane merge of a write into the held word
  function automatic logic [31:0] lane_merge(
    input logic [31:0] old_word,
    input logic [31:0] new_word,
    input logic [3:0] be
  );
    logic [31:0] w;
    w = old_word;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        w[i*8 +: 8] = new_word[i*8 +: 8];
      end
    end
    lane_merge = w;
  endfunction

  gpmx_sync u_sync (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .async_in({core_power_lost, gpi_pin}),
    .sync_out(pins_sync)
  );

  gpmx_select u_select (
    .general_configuration(general_configuration),
    .xbus_chip_select_config(xbus_chip_select_config),
    .in_alt_sel(in_alt_sel),
    .out_alt_sel(out_alt_sel)
  );

  assign in_sync = pins_sync[21:0];
  assign power_lost_sync = pins_sync[22];

  // Alternate drivers laid out by pin index; GP-only pins carry zero
  always_comb begin
    alt_drive = '0;
    alt_drive[7:1] = latched_upper_address;
    alt_drive[11:9] = pcpci_grant_n;
    alt_drive[12] = ext_intc_ack_n;
    alt_drive[13] = ext_intc_select_n;
    alt_drive[14] = ext_intc_timer_irq;
    alt_drive[15] = secondary_plane_ctl_n;
    alt_drive[16] = tertiary_plane_ctl_n;
    alt_drive[17] = processor_clock_stop_n;
    alt_drive[18] = bus_clock_stop_n;
    alt_drive[19] = cache_power_down;
    alt_drive[20] = suspend_status_one_n;
    alt_drive[21] = suspend_status_two_n;
    alt_drive[22] = xbus_direction_n;
    alt_drive[23] = xbus_output_enable_n;
    alt_drive[24] = ext_clock_select_n;
    alt_drive[25] = ext_clock_addr_strobe;
    alt_drive[26] = keyboard_ctl_select_n;
    // Level from the controller passes as is, already active low
    alt_drive[29] = interrupt_nine_out_n;
  end

  always_comb begin
    s_d = s_q;
    wr_out_hit = io_wr && addr_hit(io_addr, power_mgmt_io_base, `GPMX_OUT_LEVELS_OFF);
    rd_out_hit = addr_hit(io_addr, power_mgmt_io_base, `GPMX_OUT_LEVELS_OFF);
    rd_in_hit = addr_hit(io_addr, power_mgmt_io_base, `GPMX_IN_LEVELS_OFF);
    merged = lane_merge(s_q.out_levels, io_wdata, io_be);

    // Output level register; top bit has no pin and stays zero
    if (wr_out_hit) begin
      s_d.out_levels = {1'b0, merged[30:0]};
    end

    // Register bits drive only GP pins, alternate pins follow their logic
    pin_next = (s_q.out_levels[30:0] & ~out_alt_sel) | (alt_drive & out_alt_sel);
    // Pin 8 pulled low once the core plane drops; others are unpowered then
    if (power_lost_sync) begin
      pin_next[8] = 1'b0;
    end
    s_d.out_pins = pin_next;

    // Input levels always captured, whatever the pin is used for
    s_d.in_levels = in_sync;
    s_d.pm_in1_active = !in_sync[1];

    // Pins not handed to alternate logic look idle to it
    s_d.alt_in = (in_sync & in_alt_sel) | (`GPMX_ALT_IN_IDLE & ~in_alt_sel);

    // Reads answer next cycle; unmapped offsets read zero
    s_d.rd_valid = io_rd;
    if (io_rd) begin
      if (rd_in_hit) begin
        s_d.rdata = {10'h000, s_q.in_levels};
      end else if (rd_out_hit) begin
        s_d.rdata = s_q.out_levels;
      end else begin
        s_d.rdata = 32'h0000_0000;
      end
    end
  end

  // Reset places GP-default pins at the register value and alternate
  // pins at their own reset state; nothing else moves them until then
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign gpo_pin = s_q.out_pins;
  assign io_rdata = s_q.rdata;
  assign io_rd_valid = s_q.rd_valid;
  assign pm_input_one_active = s_q.pm_in1_active;

  // Alternate-side views of shared inputs
  assign channel_check_n = s_q.alt_in[0];
  assign pcpci_request_n = s_q.alt_in[4:2];
  assign ext_intc_request_n = s_q.alt_in[5];
  assign clock_interrupt_n = s_q.alt_in[6];
  assign serial_interrupt_line = s_q.alt_in[7];
  assign thermal_alarm_n = s_q.alt_in[8];
  assign battery_low_n = s_q.alt_in[9];
  assign lid_switch_n = s_q.alt_in[10];
  assign mgmt_bus_alert_n = s_q.alt_in[11];
  assign ring_indicate_n = s_q.alt_in[12];

endmodule

// *** gpmx_pin_mux_assertions.sv ***
// Port checker for the pin mux, bound to its top.
// Assumes one clock, async active-low reset.
`timescale 1ns/1ps
module gpmx_pin_mux_chk (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register access
  input wire logic [15:0] power_mgmt_io_base,
  input wire logic [15:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [3:0] io_be,
  input wire logic [31:0] io_wdata,
  input wire logic [31:0] io_rdata,
  input wire logic io_rd_valid,
  // Configuration and pins
  input wire logic [31:0] general_configuration,
  input wire logic [15:0] xbus_chip_select_config,
  input wire logic [21:0] gpi_pin,
  input wire logic core_power_lost,
  input wire logic [30:0] gpo_pin,
  input wire logic [6:0] latched_upper_address,
  input wire logic processor_clock_stop_n,
  input wire logic interrupt_nine_out_n,
  input wire logic serial_interrupt_line,
  input wire logic pm_input_one_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  wire logic [15:0] off = io_addr - power_mgmt_io_base;

  gp_write_a: assert property (io_wr && off == 16'h0034 && io_be == 4'hF ##1 !io_wr
    |-> ##2 {gpo_pin[30], gpo_pin[28:27], gpo_pin[0]}
    == {$past(io_wdata[30], 3), $past(io_wdata[28:27], 3), $past(io_wdata[0], 3)})
    else $error("fixed outputs differ from written word");
  eio_route_a: assert property ($past(rst_b) && $past(general_configuration[0])
    |-> gpo_pin[7:1] == $past(latched_upper_address)) else $error("address pins not routed");
  clk_stop_a: assert property ($past(rst_b) && !$past(general_configuration[18])
    |-> gpo_pin[17] == $past(processor_clock_stop_n)) else $error("clock stop not routed");
  irq_nine_a: assert property ($past(rst_b) && $past(xbus_chip_select_config[8])
    |-> gpo_pin[29] == $past(interrupt_nine_out_n)) else $error("interrupt nine not routed");
  rd_pulse_a: assert property ($past(rst_b) |-> io_rd_valid == $past(io_rd))
    else $error("read valid not one cycle after read");
  unmapped_read_a: assert property (io_rd && off != 16'h0030 && off != 16'h0034
    |=> io_rdata == 32'h0000_0000) else $error("unmapped read not zero");
  power_loss_a: assert property (core_power_lost [*5] |-> !gpo_pin[8])
    else $error("output 8 not low on power loss");
  serial_idle_a: assert property (!general_configuration[16] [*2] |-> serial_interrupt_line)
    else $error("serial line not idle");
  pm_one_a: assert property (!gpi_pin[1] [*5] |-> pm_input_one_active)
    else $error("input one low not seen active");
endmodule

bind gpmx_pin_mux gpmx_pin_mux_chk chk (.ref_clk, .rst_b, .power_mgmt_io_base, .io_addr,
  .io_wr, .io_rd, .io_be, .io_wdata, .io_rdata, .io_rd_valid, .general_configuration,
  .xbus_chip_select_config, .gpi_pin, .core_power_lost, .gpo_pin, .latched_upper_address,
  .processor_clock_stop_n, .interrupt_nine_out_n, .serial_interrupt_line,
  .pm_input_one_active);

// *** gpmx_pkg.sv ***
// Types for the general-purpose pin mux.
// Assumes gpmx_regs.svh is compiled alongside.
package gpmx_pkg;

  typedef struct packed {
    logic [31:0] out_levels;
    logic [30:0] out_pins;
    logic [21:0] in_levels;
    logic [21:0] alt_in;
    logic pm_in1_active;
    logic [31:0] rdata;
    logic rd_valid;
  } gpmx_state_t;

  typedef struct packed {
    logic [1:0] [22:0] stage;
  } gpmx_sync_t;

endpackage

// *** gpmx_regs.svh ***
// Constants for the general-purpose pin mux: offsets, field positions,
// reset values. Assumes includers compile it once per unit.
`ifndef GPMX_REGS_SVH
`define GPMX_REGS_SVH

// Power-management I/O space offsets above the base
`define GPMX_IN_LEVELS_OFF 16'h0030
`define GPMX_OUT_LEVELS_OFF 16'h0034

// Widths
`define GPMX_NUM_IN 22
`define GPMX_NUM_OUT 31

// General configuration fields
`define GPMX_CFG_EXT_IO 0
`define GPMX_CFG_PCPCI_LO 8
`define GPMX_CFG_CLK_IRQ 14
`define GPMX_CFG_ALERT 15
`define GPMX_CFG_SERIAL_INTERRUPT_LINE 16
`define GPMX_CFG_SUSP_PLANES 17
`define GPMX_CFG_CPU_STOP 18
`define GPMX_CFG_BUS_STOP 19
`define GPMX_CFG_CACHE_PD 20
`define GPMX_CFG_SUSP_STAT1 21
`define GPMX_CFG_SUSP_STAT2 22
`define GPMX_CFG_THERMAL 23
`define GPMX_CFG_BATT_LOW 24
`define GPMX_CFG_LID 25
`define GPMX_CFG_RING 27
`define GPMX_CFG_XBUS_XCVR 28
`define GPMX_CFG_CLK_CS 29
`define GPMX_CFG_CLK_ALE 30
`define GPMX_CFG_KBC_CS 31
// X-bus chip-select configuration field
`define GPMX_XBUS_CHIP_SELECT_CONFIG_EXT_INTC 8

// Reset values
`define GPMX_OUT_LEVELS_RESET 32'h0000_0000
`define GPMX_ALT_DEFAULT_MASK 31'h07FF_8000
`define GPMX_ALT_RESET 31'h05C6_0000
`define GPMX_ALT_IN_IDLE 22'h3F_FFFF

`endif

// *** gpmx_select.sv ***
// Decodes which shared pins run their alternate function.
// Assumes configuration inputs are steady on ref_clk; purely combinational.
`timescale 1ns/1ps
`include "gpmx_regs.svh"
module gpmx_select (
  // Configuration
  input wire logic [31:0] general_configuration,
  input wire logic [15:0] xbus_chip_select_config,
  // Alternate selects, one bit per pin
  output logic [21:0] in_alt_sel,
  output logic [30:0] out_alt_sel
);
  logic ext_intc;
  logic ext_io;

  always_comb begin
    ext_intc = xbus_chip_select_config[`GPMX_XBUS_CHIP_SELECT_CONFIG_EXT_INTC];
    // Bit set is extended bus mode, so reset leaves these pins on GP use
    ext_io = !general_configuration[`GPMX_CFG_EXT_IO];
    in_alt_sel = '0;
    out_alt_sel = '0;
    in_alt_sel[0] = !ext_io;
    out_alt_sel[7:1] = {7{!ext_io}};
    in_alt_sel[4:2] = general_configuration[`GPMX_CFG_PCPCI_LO +: 3];
    out_alt_sel[11:9] = general_configuration[`GPMX_CFG_PCPCI_LO +: 3];
    in_alt_sel[5] = ext_intc;
    out_alt_sel[14:12] = {3{ext_intc}};
    out_alt_sel[29] = ext_intc;
    in_alt_sel[6] = general_configuration[`GPMX_CFG_CLK_IRQ];
    in_alt_sel[7] = general_configuration[`GPMX_CFG_SERIAL_INTERRUPT_LINE];
    // Feature bits clear select the feature, so reset lands on the default
    in_alt_sel[8] = !general_configuration[`GPMX_CFG_THERMAL];
    in_alt_sel[9] = !general_configuration[`GPMX_CFG_BATT_LOW];
    in_alt_sel[10] = !general_configuration[`GPMX_CFG_LID];
    in_alt_sel[11] = !general_configuration[`GPMX_CFG_ALERT];
    in_alt_sel[12] = !general_configuration[`GPMX_CFG_RING];
    out_alt_sel[16:15] = {2{!general_configuration[`GPMX_CFG_SUSP_PLANES]}};
    out_alt_sel[17] = !general_configuration[`GPMX_CFG_CPU_STOP];
    out_alt_sel[18] = !general_configuration[`GPMX_CFG_BUS_STOP];
    out_alt_sel[19] = !general_configuration[`GPMX_CFG_CACHE_PD];
    out_alt_sel[20] = !general_configuration[`GPMX_CFG_SUSP_STAT1];
    out_alt_sel[21] = !general_configuration[`GPMX_CFG_SUSP_STAT2];
    out_alt_sel[23:22] = {2{!general_configuration[`GPMX_CFG_XBUS_XCVR]}};
    out_alt_sel[24] = !general_configuration[`GPMX_CFG_CLK_CS];
    out_alt_sel[25] = !general_configuration[`GPMX_CFG_CLK_ALE];
    out_alt_sel[26] = !general_configuration[`GPMX_CFG_KBC_CS];
    // Inputs 1, 13..21 and outputs 0, 8, 27, 28, 30 never leave GP use
  end
endmodule

// *** gpmx_sync.sv ***
// Two-flop synchroniser for the pin inputs.
// Assumes ref_clk domain; inputs may change at any time.
`timescale 1ns/1ps
module gpmx_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Data
  input wire logic [22:0] async_in,
  output logic [22:0] sync_out
);
  gpmx_pkg::gpmx_sync_t s_q;
  gpmx_pkg::gpmx_sync_t s_d;

  // First stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.stage[0] = async_in;
    s_d.stage[1] = s_q.stage[0];
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Pin stages rest high like pulled-up lines, so no false alert after reset
      s_q <= {2{23'h3F_FFFF}};
    end else begin
      s_q <= s_d;
    end
  end

  assign sync_out = s_q.stage[1];
endmodule

// *** test_gpmx_pin_mux.sv ***
// Self-checking bench for the pin mux.
// Assumes the board model and the bound checker compile alongside.
`timescale 1ns/1ps
module test_gpmx_pin_mux;
  localparam logic [15:0] BASE = 16'h4000;
  localparam logic [31:0] ALL_GP = 32'hFBFE_8000;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] io_addr = 16'h0000;
  logic io_wr = 1'b0;
  logic io_rd = 1'b0;
  logic [3:0] io_be = 4'h0;
  logic [31:0] io_wdata = 32'h0000_0000;
  logic [31:0] gc = 32'h0000_0000;
  logic [15:0] xb = 16'h0000;
  logic [25:0] alt_v = 26'h000_0000;
  logic [21:0] want = 22'h00_0000;
  logic want_pl = 1'b0;
  logic [21:0] gpi_pin;
  logic core_power_lost;
  logic [31:0] io_rdata;
  logic io_rd_valid;
  logic [30:0] gpo_pin;
  wire logic [11:0] alt_in;
  logic pm_one;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;

  gpmx_board #(.LAG(2)) board (.ref_clk, .want_pins(want), .want_power_lost(want_pl),
    .gpi_pin, .core_power_lost);
  gpmx_pin_mux dut (.ref_clk, .rst_b, .power_mgmt_io_base(BASE), .io_addr, .io_wr, .io_rd,
    .io_be, .io_wdata, .io_rdata, .io_rd_valid, .general_configuration(gc),
    .xbus_chip_select_config(xb), .gpi_pin, .core_power_lost, .gpo_pin,
    .latched_upper_address(alt_v[6:0]), .pcpci_grant_n(alt_v[9:7]),
    .ext_intc_ack_n(alt_v[10]), .ext_intc_select_n(alt_v[11]), .ext_intc_timer_irq(alt_v[12]),
    .secondary_plane_ctl_n(alt_v[13]), .tertiary_plane_ctl_n(alt_v[14]),
    .processor_clock_stop_n(alt_v[15]), .bus_clock_stop_n(alt_v[16]),
    .cache_power_down(alt_v[17]), .suspend_status_one_n(alt_v[18]),
    .suspend_status_two_n(alt_v[19]), .xbus_direction_n(alt_v[20]),
    .xbus_output_enable_n(alt_v[21]), .ext_clock_select_n(alt_v[22]),
    .ext_clock_addr_strobe(alt_v[23]), .keyboard_ctl_select_n(alt_v[24]),
    .interrupt_nine_out_n(alt_v[25]), .channel_check_n(alt_in[0]),
    .pcpci_request_n(alt_in[3:1]), .ext_intc_request_n(alt_in[4]),
    .clock_interrupt_n(alt_in[5]), .serial_interrupt_line(alt_in[6]),
    .thermal_alarm_n(alt_in[7]), .battery_low_n(alt_in[8]), .lid_switch_n(alt_in[9]),
    .mgmt_bus_alert_n(alt_in[10]), .ring_indicate_n(alt_in[11]),
    .pm_input_one_active(pm_one));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Generous ceiling: the whole run needs well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  // Strobe lowered then one idle edge, so back-to-back calls never retoggle in one step
  task automatic wr(input logic [15:0] off, input logic [3:0] be, input logic [31:0] d);
    io_addr = BASE + off;
    io_be = be;
    io_wdata = d;
    io_wr = 1'b1;
    tick(1);
    io_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [15:0] off, output logic [31:0] d);
    io_addr = BASE + off;
    io_rd = 1'b1;
    tick(1);
    io_rd = 1'b0;
    check("read valid", {31'h0, io_rd_valid}, 32'h0000_0001);
    d = io_rdata;
    tick(1);
  endtask
  function automatic logic [30:0] alt_sel(input logic [31:0] g, input logic [15:0] x);
    alt_sel = {1'b0, x[8], 2'b00, ~g[31:29], {2{~g[28]}}, ~g[22:20], ~g[19], ~g[18],
      {2{~g[17]}}, {3{x[8]}}, g[10:8], 1'b0, {7{g[0]}}, 1'b0};
  endfunction

  task automatic t_reset();
    tick(8);
    check("reset pins", gpo_pin, 32'h05C6_0000);
    tick(8);
    rst_b = 1'b1;
    for (int i = 0; i < 8; i++) begin
      alt_v = ~alt_v;
      tick(1);
      check("gp default pins", gpo_pin & 31'h7800_7FFF, 32'h0);
    end
    $display("test reset done");
  endtask
  task automatic t_mux();
    logic [30:0] m;
    logic [30:0] aw;
    wr(16'h0034, 4'hF, 32'h5A5A_A5A5);
    for (int i = 0; i <= 32; i++) begin
      gc = (i == 32) ? 32'h0 : 32'h1 << i;
      xb = {7'h00, i[0], 8'h00};
      alt_v = i[1] ? 26'h2AA_AAAA : 26'h155_5555;
      tick(2);
      m = alt_sel(gc, xb);
      aw = {1'b0, alt_v[25], 2'b00, alt_v[24:7], 1'b0, alt_v[6:0], 1'b0};
      check("muxed pins", gpo_pin, (31'h5A5A_A5A5 & ~m) | (aw & m));
    end
    $display("test mux done");
  endtask
  task automatic t_regs();
    logic [31:0] d;
    gc = ALL_GP;
    wr(16'h0034, 4'hF, 32'hFFFF_FFFF);
    wr(16'h0034, 4'h2, 32'h0000_0000);
    wr(16'h0030, 4'hF, 32'h0000_0000);
    rd(16'h0034, d);
    check("output register", d, 32'h7FFF_00FF);
    check("gp pins", gpo_pin, 32'h7FFF_00FF);
    rd(16'h0038, d);
    check("unmapped read", d, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_inputs();
    logic [31:0] d;
    logic [21:0] p;
    for (int k = 0; k < 2; k++) begin
      p = k ? 22'h2A_5A5A : 22'h15_A5A5;
      gc = ALL_GP;
      xb = 16'h0000;
      want = p;
      tick(8);
      rd(16'h0030, d);
      check("input register", d, {10'h000, p});
      check("idle alternates", alt_in, 32'hFFF);
      check("input one active", pm_one, !p[1]);
      gc = 32'h0001_4701;
      xb = 16'h0100;
      tick(2);
      check("alternate inputs", alt_in, {p[12:2], p[0]});
    end
    $display("test inputs done");
  endtask
  task automatic t_power();
    gc = ALL_GP;
    xb = 16'h0000;
    wr(16'h0034, 4'hF, 32'h0000_0100);
    check("pin 8 high", gpo_pin, 32'h0000_0100);
    want_pl = 1'b1;
    tick(8);
    check("pin 8 on power loss", gpo_pin, 32'h0);
    want_pl = 1'b0;
    tick(8);
    check("pin 8 restored", gpo_pin, 32'h0000_0100);
    $display("test power done");
  endtask

  initial begin
    t_reset();
    t_mux();
    t_regs();
    t_inputs();
    t_power();
    conclude();
  end
endmodule
